// ===== src/spseq_pkg.sv
// package for the set point program sequencer
// assumes one clock domain and plain ports for all settings
package spseq_pkg;
  // ==========================================================
  // program shape
  localparam int unsigned SPSEQ_STEPS = 16;
  localparam int unsigned SPSEQ_SP_W = 16;
  localparam int unsigned SPSEQ_TIME_W = 16;
  localparam int unsigned SPSEQ_IDX_W = 4;
  // ==========================================================
  // timing
  localparam int unsigned SPSEQ_CLK_HZ = 10_000_000;
  localparam int unsigned SPSEQ_TICK_S = 1;
  localparam int unsigned SPSEQ_TICK_CYC = SPSEQ_CLK_HZ * SPSEQ_TICK_S;
  // ==========================================================
  // defaults and program source code
  localparam logic [SPSEQ_STEPS-1:0] SPSEQ_MASK_DEF = 16'hFFFF;
  localparam logic [SPSEQ_SP_W-1:0] SPSEQ_SP_RST = 16'h0000;
  localparam logic [1:0] SPSEQ_SRC_PROG = 2'h2;

  typedef enum logic [1:0] {
    SPSEQ_IDLE = 2'b00,
    SPSEQ_SEEK = 2'b01,
    SPSEQ_RAMP = 2'b11,
    SPSEQ_DONE = 2'b10
  } spseq_state_e;

  typedef struct packed {
    logic [SPSEQ_SP_W-1:0] target;
    logic [SPSEQ_TIME_W-1:0] secs;
  } spseq_step_s;

  typedef struct packed {
    logic we;
    logic [SPSEQ_IDX_W-1:0] idx;
    spseq_step_s step;
  } spseq_wr_s;
endpackage

// ===== src/spseq_top.sv
// set point program sequencer: stores up to sixteen ramp steps and
// drives a set point to the flow loop; settings arrive as plain ports,
// persistence writes leave as one-cycle store requests
`timescale 1ns/1ps
module spseq_top
  import spseq_pkg::*;
#(
  parameter int unsigned TICK_CYC = SPSEQ_TICK_CYC
)(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic prog_enable,
  input wire logic repeat_en,
  input wire logic loop_cfg_valid,
  input wire logic [1:0] sp_source,
  input wire logic run_on,
  input wire spseq_pkg::spseq_wr_s step_wr,
  input wire logic mask_we,
  input wire logic [spseq_pkg::SPSEQ_STEPS-1:0] mask_wdata,
  output logic [spseq_pkg::SPSEQ_SP_W-1:0] setpoint,
  output logic [spseq_pkg::SPSEQ_IDX_W-1:0] cur_step,
  output logic active,
  output logic finished,
  output logic [spseq_pkg::SPSEQ_STEPS-1:0] step_mask,
  output logic nv_mask_store,
  output logic nv_step_store,
  output spseq_pkg::spseq_step_s nv_step_data,
  output logic [spseq_pkg::SPSEQ_IDX_W-1:0] nv_step_idx
);
  import spseq_pkg::*;

  initial
  begin
    if (TICK_CYC < 1 || TICK_CYC > 32'hFFFF_FFFF)
      $error("tick count out of range");
  end

  // ==========================================================
  // step table and mask
  spseq_step_s table_q [SPSEQ_STEPS];
  logic [SPSEQ_STEPS-1:0] mask_q;
  spseq_state_e state_q, state_d;
  logic [SPSEQ_IDX_W-1:0] idx_q;
  logic [SPSEQ_SP_W-1:0] sp_q, start_q;
  logic [SPSEQ_TIME_W-1:0] sec_q;
  logic [31:0] tick_q;

  always_ff @(posedge ref_clk)
  begin
    if (step_wr.we)
      table_q[step_wr.idx] <= step_wr.step;
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      mask_q <= SPSEQ_MASK_DEF;
    else if (mask_we)
      mask_q <= mask_wdata;
  end

  // persistence requests mirror writes taken outside srst; a step write during srst still reaches the table but raises no request
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      nv_mask_store <= 1'b0;
      nv_step_store <= 1'b0;
      nv_step_data <= '0;
      nv_step_idx <= '0;
    end
    else
    begin
      nv_mask_store <= mask_we;
      nv_step_store <= step_wr.we;
      if (step_wr.we)
      begin
        nv_step_data <= step_wr.step;
        nv_step_idx <= step_wr.idx;
      end
    end
  end

  // ==========================================================
  // next enabled step search
  wire logic enabled_w = prog_enable && (sp_source == SPSEQ_SRC_PROG)
                         && loop_cfg_valid;
  wire logic go_w = enabled_w && run_on;
  logic [SPSEQ_IDX_W-1:0] next_idx;
  logic next_found, first_found;
  logic [SPSEQ_IDX_W-1:0] first_idx;

  // first set bit above idx_q (any set bit while idle), and first set bit overall
  always_comb
  begin
    next_idx = '0;
    next_found = 1'b0;
    first_idx = '0;
    first_found = 1'b0;
    for (int i = SPSEQ_STEPS - 1; i >= 0; i--)
    begin
      if (mask_q[i])
      begin
        first_idx = SPSEQ_IDX_W'(i);
        first_found = 1'b1;
        if (i > int'(idx_q) || state_q == SPSEQ_IDLE)
        begin
          next_idx = SPSEQ_IDX_W'(i);
          next_found = 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // linear interpolation; divider is combinational, fine at 10 MHz
  spseq_step_s cur_w;
  assign cur_w = table_q[idx_q];
  wire logic sec_tick_w = (tick_q == TICK_CYC - 1);
  wire logic [SPSEQ_TIME_W-1:0] sec_next_w = sec_q + 1'b1;
  wire logic step_end_w = (cur_w.secs == '0) || (sec_tick_w && sec_next_w >= cur_w.secs);
  logic signed [SPSEQ_SP_W+SPSEQ_TIME_W+1:0] delta_w;
  logic [SPSEQ_SP_W-1:0] interp_w;
  always_comb
  begin
    delta_w = ($signed({2'b00, cur_w.target}) - $signed({2'b00, start_q}))
              * $signed({1'b0, sec_next_w});
    if (cur_w.secs == '0)
      interp_w = cur_w.target;
    else
      interp_w = SPSEQ_SP_W'($signed({2'b00, start_q})
                 + delta_w / $signed({1'b0, cur_w.secs}));
  end

  // ==========================================================
  // sequencer state
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      SPSEQ_IDLE:
        if (go_w && first_found)
          state_d = SPSEQ_RAMP;
      SPSEQ_RAMP:
        if (!enabled_w)
          state_d = SPSEQ_IDLE;
        else if (go_w && step_end_w)
          state_d = SPSEQ_SEEK;
      SPSEQ_SEEK:
        if (!enabled_w)
          state_d = SPSEQ_IDLE;
        else if (go_w)
        begin
          if (next_found)
            state_d = SPSEQ_RAMP;
          else if (repeat_en && first_found)
            state_d = SPSEQ_RAMP;
          else if (!first_found)
            state_d = SPSEQ_SEEK;
          else
            state_d = SPSEQ_DONE;
        end
      SPSEQ_DONE:
        if (!enabled_w)
          state_d = SPSEQ_IDLE;
      default:
        state_d = SPSEQ_IDLE;
    endcase
  end

  wire logic load_w = (state_q != SPSEQ_RAMP) && (state_d == SPSEQ_RAMP);
  wire logic [SPSEQ_IDX_W-1:0] load_idx_w = next_found ? next_idx : first_idx;

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      state_q <= SPSEQ_IDLE;
      idx_q <= '0;
      sp_q <= SPSEQ_SP_RST;
      start_q <= SPSEQ_SP_RST;
      sec_q <= '0;
      tick_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      if (load_w)
      begin
        idx_q <= load_idx_w;
        start_q <= sp_q;
        sec_q <= '0;
        tick_q <= '0;
      end
      else if (state_q == SPSEQ_RAMP && go_w)
      begin
        if (cur_w.secs == '0)
          sp_q <= cur_w.target;
        else if (sec_tick_w)
        begin
          tick_q <= '0;
          sec_q <= sec_next_w;
          sp_q <= step_end_w ? cur_w.target : interp_w;
        end
        else
          tick_q <= tick_q + 1'b1;
      end
    end
  end

  assign setpoint = sp_q;
  assign cur_step = idx_q;
  assign active = (state_q == SPSEQ_RAMP) || (state_q == SPSEQ_SEEK);
  assign finished = (state_q == SPSEQ_DONE);
  assign step_mask = mask_q;
endmodule

// ===== verification/spseq_checker.sv
// checker on the sequencer top ports
// assumes one clock, srst sync high
`timescale 1ns/1ps
module spseq_checker
  import spseq_pkg::*;
#(
  parameter int unsigned TICK_CYC = 4
)(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic prog_enable,
  input wire logic loop_cfg_valid,
  input wire logic [1:0] sp_source,
  input wire logic run_on,
  input wire spseq_pkg::spseq_wr_s step_wr,
  input wire logic mask_we,
  input wire logic [15:0] mask_wdata,
  input wire logic [15:0] setpoint,
  input wire logic active,
  input wire logic finished,
  input wire logic [15:0] step_mask,
  input wire logic nv_mask_store,
  input wire logic nv_step_store,
  input wire spseq_pkg::spseq_step_s nv_step_data
);
  // ==========
  // properties
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  wire logic go = prog_enable && sp_source == SPSEQ_SRC_PROG && loop_cfg_valid && run_on;
  sequence s_go;
    !active && !finished && go && step_mask != 16'h0000 && !mask_we;
  endsequence
  rst_vals_a: assert property (disable iff (1'b0) srst |=>
    setpoint == 16'h0000 && !active && !finished && step_mask == 16'hFFFF) else $error("reset");
  go_start_a: assert property (s_go |=> active)
    else $error("no start");
  cfg_drop_a: assert property (!prog_enable || !loop_cfg_valid |=> !active)
    else $error("active while off");
  pause_hold_a: assert property (!run_on |=> $stable(setpoint))
    else $error("moved in pause");
  done_hold_a: assert property (finished |=> $stable(setpoint))
    else $error("moved when done");
  no_mask_a: assert property (step_mask == 16'h0000 && !active && !mask_we |=>
    !active && $stable(setpoint)) else $error("ran all masked");
  mask_store_a: assert property (mask_we |=> nv_mask_store &&
    step_mask == $past(mask_wdata)) else $error("mask store");
  step_store_a: assert property (step_wr.we |=> nv_step_store &&
    nv_step_data == $past(step_wr.step)) else $error("step store");
endmodule
bind spseq_top spseq_checker #(.TICK_CYC(TICK_CYC)) u_chk (.ref_clk, .srst, .prog_enable,
  .loop_cfg_valid, .sp_source, .run_on, .step_wr, .mask_we, .mask_wdata, .setpoint, .active,
  .finished, .step_mask, .nv_mask_store, .nv_step_store, .nv_step_data);

// ===== verification/spseq_flow_model.sv
// flow loop stand-in taking the set point
// assumes one clock; it only follows
`timescale 1ns/1ps
module spseq_flow_model
(
  input wire logic ref_clk,
  input wire logic [15:0] setpoint,
  output logic [15:0] applied_sp
);
  // ==========
  // demand lags one clock, as a sampled loop would
  always_ff @(posedge ref_clk)
  begin
    applied_sp <= setpoint;
  end
endmodule

// ===== verification/tb_setpoint_program_sequencer.sv
// bench for the sequencer, tick shortened to 4 clocks
// assumes the checker is bound by its own file
`timescale 1ns/1ps
module tb_setpoint_program_sequencer;
  import spseq_pkg::*;
  logic ref_clk = 0, srst = 1, prog_enable = 0, repeat_en = 0, loop_cfg_valid = 0;
  logic run_on = 0, mask_we = 0, active, finished;
  logic [1:0] sp_source = 2'h0;
  logic [15:0] mask_wdata = 16'h0000, setpoint, step_mask, applied_sp;
  logic [3:0] cur_step;
  spseq_wr_s step_wr = '0;
  int mismatches = 0, checks = 0;
  spseq_top #(.TICK_CYC(4)) u_dut (.ref_clk, .srst, .prog_enable, .repeat_en,
    .loop_cfg_valid, .sp_source, .run_on, .step_wr, .mask_we, .mask_wdata, .setpoint,
    .cur_step, .active, .finished, .step_mask, .nv_mask_store(), .nv_step_store(),
    .nv_step_data(), .nv_step_idx());
  spseq_flow_model u_flow (.ref_clk, .setpoint, .applied_sp);
  // ==========
  // helpers
  initial
  begin
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic cyc(input int n = 1);
    repeat (n) @(posedge ref_clk);
    #5;
  endtask
  task automatic check(input bit ok, input string m);
    checks++;
    if (!ok)
    begin
      mismatches++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic wait_sp(input logic [15:0] e);
    logic [15:0] o;
    o = setpoint;
    for (int i = 0; i < 40 && setpoint === o; i++)
      cyc();
    check(setpoint === e, "set point");
  endtask
  task automatic wr_step(input logic [3:0] i, input logic [15:0] t, s);
    step_wr = '{1'b1, i, '{t, s}};
    cyc();
    step_wr.we = 1'b0;
    cyc();
  endtask
  task automatic set_mask(input logic [15:0] m);
    mask_wdata = m;
    mask_we = 1'b1;
    cyc();
    mask_we = 1'b0;
    cyc();
    check(step_mask === m, "mask");
  endtask
  task automatic go(input logic r);
    sp_source = SPSEQ_SRC_PROG;
    loop_cfg_valid = 1'b1;
    repeat_en = r;
    run_on = 1'b1;
    prog_enable = 1'b1;
  endtask
  // ==========
  // scenarios
  task automatic t_reset;
    check(setpoint === 16'h0000 && active === 1'b0 && finished === 1'b0, "rst");
    check(step_mask === 16'hFFFF, "mask default");
    $display("reset done");
  endtask
  task automatic t_run;
    wr_step(4'h0, 16'h0100, 16'h0002);
    wr_step(4'h1, 16'hFFFF, 16'h0001);
    wr_step(4'h2, 16'h0000, 16'h0000);
    wr_step(4'h3, 16'h0400, 16'h0004);
    wr_step(4'hF, 16'h0040, 16'h0000);
    set_mask(16'h000D);
    go(1'b0);
    wait_sp(16'h0080);
    wait_sp(16'h0100);
    wait_sp(16'h0000);
    check(cur_step === 4'h2, "skip");
    wait_sp(16'h0100);
    run_on = 1'b0;
    cyc(12);
    check(setpoint === 16'h0100, "pause");
    run_on = 1'b1;
    wait_sp(16'h0200);
    wait_sp(16'h0300);
    wait_sp(16'h0400);
    cyc(12);
    check(finished === 1'b1 && setpoint === 16'h0400, "hold last");
    check(applied_sp === setpoint, "loop follows");
    $display("run done");
  endtask
  task automatic t_loop;
    prog_enable = 1'b0;
    cyc(2);
    set_mask(16'h0005);
    go(1'b1);
    wait_sp(16'h0280);
    wait_sp(16'h0100);
    wait_sp(16'h0000);
    wait_sp(16'h0080);
    repeat_en = 1'b0;
    wait_sp(16'h0100);
    wait_sp(16'h0000);
    cyc(12);
    check(finished === 1'b1 && setpoint === 16'h0000, "loop off");
    $display("loop done");
  endtask
  task automatic t_masked;
    prog_enable = 1'b0;
    cyc(2);
    set_mask(16'h0000);
    go(1'b1);
    cyc(12);
    check(active === 1'b0 && setpoint === 16'h0000, "all masked");
    sp_source = 2'h1;
    set_mask(16'h8000);
    cyc(8);
    check(active === 1'b0, "source");
    sp_source = SPSEQ_SRC_PROG;
    wait_sp(16'h0040);
    check(cur_step === 4'hF, "last index");
    $display("masked done");
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    #500000;
    mismatches++;
    summarize();
  end
  initial
  begin
    cyc(3);
    srst = 1'b0;
    cyc();
    t_reset();
    t_run();
    t_loop();
    t_masked();
    summarize();
  end
endmodule
